/* logic/wavetable_pkg.sv */
// Shared constants and types for the wavetable voice engine
// Functional notes
// - Sixteen voices chosen by four-bit voice index.
// - Trigger register write in mode all launches the addressed voice.
// - Update mode selects all, pitch or volume.
// - Step 800H octave 6 advances one sample.
// - Advance equals increment over two^(17-octave).
// - Start word address is base times 32.
// - Width bit selects 8-bit or 12-bit samples.
// - Play once, then loop until volume decays.
// - Loop point is end address plus offset.
// - Ten-bit attenuation, zero loudest, 3FFH quietest.
// - Attack ramps bits to zeros, release to ones.
// - Depth field picks ramped bits, 11 holds.
// - Signed 8-bit samples, 80H marks the end.
package wavetable_pkg;
	// ************************************************
	// Register map
	// ************************************************
	localparam logic [7:0] ADDR_TRIGGER = 8'h20;
	localparam logic [7:0] ADDR_PITCH_HI = 8'h21;
	localparam logic [7:0] ADDR_PITCH_LO = 8'h22;
	localparam logic [7:0] ADDR_BASE_HI = 8'h23;
	localparam logic [7:0] ADDR_BASE_LO = 8'h24;
	localparam logic [7:0] ADDR_SHAPE_HI = 8'h25;
	localparam logic [7:0] ADDR_LOOP_LO = 8'h26;
	localparam logic [7:0] ADDR_ENV_HI = 8'h27;
	localparam logic [7:0] ADDR_LEFT_LO = 8'h29;
	localparam logic [7:0] ADDR_RIGHT_LO = 8'h2a;
	localparam logic [7:0] ENV_HI_MASK = 8'hbf;
	// ************************************************
	// Field layout
	// ************************************************
	localparam int VOICES = 16;
	localparam int VOICE_W = 4;
	localparam logic [3:0] VOICE_LAST = 4'hf;
	localparam int VOICE_LSB = 0;
	localparam int MODE_LSB = 6;
	localparam int MODE_W = 2;
	localparam logic [1:0] MODE_ALL = 2'b00;
	localparam logic [1:0] MODE_PITCH = 2'b01;
	localparam logic [1:0] MODE_VOLUME = 2'b10;
	localparam int OCT_LSB = 4;
	localparam int WIDTH_BIT = 7;
	localparam int DIR_BIT = 7;
	localparam int LGAIN_LSB = 4;
	localparam int DEPTH_LSB = 2;
	localparam int RGAIN_LSB = 0;
	localparam int BASE_SHIFT = 5;
	// ************************************************
	// Datapath widths and codes
	// ************************************************
	localparam int INC_W = 12;
	localparam int OCT_W = 4;
	localparam int FRAC_BITS = 17;
	localparam int STEP_W = 27;
	localparam int ADV_W = STEP_W - FRAC_BITS;
	localparam int SP_W = 17;
	localparam int LOOP_W = 15;
	localparam logic [11:0] UNITY_INC = 12'h800;
	localparam logic [3:0] UNITY_OCT = 4'h6;
	localparam logic [7:0] END_CODE = 8'h80;
	localparam int GAIN_W = 10;
	localparam logic [9:0] GAIN_MIN_LEVEL = 10'h3ff;
	localparam logic [1:0] DEPTH_LOW3 = 2'b00;
	localparam logic [1:0] DEPTH_LOW2 = 2'b01;
	localparam logic [1:0] DEPTH_LOW1 = 2'b10;
	localparam logic [1:0] DEPTH_NONE = 2'b11;
	localparam logic [9:0] RAMP_MASK_3 = 10'h007;
	localparam logic [9:0] RAMP_MASK_2 = 10'h003;
	localparam logic [9:0] RAMP_MASK_1 = 10'h001;
	localparam int SAMPLE_W = 16;
	localparam int PROD_W = 27;
	localparam int ACC_W = 22;
	localparam logic [15:0] SAT_POS = 16'h7fff;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	// ************************************************
	// Timing and buffering
	// ************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int OUT_PERIOD_NS = 20000;
	localparam int PERIOD_CYCLES = OUT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 11;
	localparam logic [10:0] PERIOD_LAST = 11'(PERIOD_CYCLES - 1);
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 32;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_WAIT = 3'b010,
		ST_MIX = 3'b011,
		ST_PUSH = 3'b100
	} engine_state_t;
endpackage

/* logic/stream_fifo.sv */
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	// Pointers wrap naturally, so depth must be a power of two
	localparam int PTR_W = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W:0] count;
	} fifo_t;
	fifo_t f_reg;
	fifo_t f_next;
	logic push;
	logic pop;

	assign in_ready = f_reg.count != (PTR_W+1)'(DEPTH);
	assign out_valid = f_reg.count != '0;
	assign out_data = f_reg.mem[f_reg.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		f_next = f_reg;
		if (push) begin
			f_next.mem[f_reg.wr_ptr] = in_data;
			f_next.wr_ptr = f_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			f_next.rd_ptr = f_reg.rd_ptr + 1'b1;
		end
		case ({push, pop})
			2'b10: begin
				f_next.count = f_reg.count + 1'b1;
			end
			2'b01: begin
				f_next.count = f_reg.count - 1'b1;
			end
			default: begin
				f_next.count = f_reg.count;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end
endmodule

/* logic/wavetable_voice_engine.sv */
// Sixteen-voice wavetable engine: special registers, voice sequencer, stereo mixer
`timescale 1ns/1ps
module wavetable_voice_engine
	import wavetable_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Special register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Wave ROM fetch
	output logic [15:0] sample_fetch_bus,
	output logic rom_req,
	input wire logic rom_valid,
	input wire logic [15:0] rom_data,
	// Stereo sample stream
	output logic audio_valid,
	input wire logic audio_ready,
	output logic [15:0] audio_left,
	output logic [15:0] audio_right
);
	typedef struct packed {
		logic [7:0] trig;
		logic [7:0] pitch_hi;
		logic [7:0] pitch_lo;
		logic [7:0] base_hi;
		logic [7:0] base_lo;
		logic [7:0] shape_hi;
		logic [7:0] loop_lo;
		logic [7:0] env_hi;
		logic [7:0] left_lo;
		logic [7:0] right_lo;
		logic [7:0] rdata;
		logic [VOICES-1:0] active;
		logic [VOICES-1:0][INC_W-1:0] inc;
		logic [VOICES-1:0][OCT_W-1:0] oct;
		logic [VOICES-1:0][SP_W-1:0] sp;
		logic [VOICES-1:0][FRAC_BITS-1:0] frac;
		logic [VOICES-1:0] wide;
		logic [VOICES-1:0][LOOP_W-1:0] loopoff;
		logic [VOICES-1:0][GAIN_W-1:0] lg;
		logic [VOICES-1:0][GAIN_W-1:0] rg;
		logic [VOICES-1:0] dir;
		logic [VOICES-1:0][1:0] depth;
		engine_state_t state;
		logic [VOICE_W-1:0] vidx;
		logic [TIMER_W-1:0] timer;
		logic tick_pend;
		logic [15:0] fetch_addr;
		logic [15:0] word;
		logic signed [ACC_W-1:0] acc_l;
		logic signed [ACC_W-1:0] acc_r;
	} engine_t;
	engine_t eng_reg;
	engine_t eng_next;

	// ************************************************
	// Field decode and current-voice datapath
	// ************************************************
	logic [INC_W-1:0] sh_inc;
	logic [OCT_W-1:0] sh_oct;
	logic [15:0] sh_start_wa;
	logic [SP_W-1:0] sh_start_sp;
	logic sh_wide;
	logic [LOOP_W-1:0] sh_loop;
	logic [GAIN_W-1:0] sh_lg;
	logic [GAIN_W-1:0] sh_rg;
	logic trig_wr;
	logic [VOICE_W-1:0] trig_voice;
	logic [MODE_W-1:0] trig_mode;
	logic [VOICE_W-1:0] v;
	logic [SP_W-1:0] c_sp;
	logic [FRAC_BITS-1:0] c_frac;
	logic [INC_W-1:0] c_inc;
	logic [OCT_W-1:0] c_oct;
	logic c_wide;
	logic [LOOP_W-1:0] c_loop;
	logic [GAIN_W-1:0] c_lg;
	logic [GAIN_W-1:0] c_rg;
	logic c_dir;
	logic [1:0] c_depth;
	logic [7:0] byte_pick;
	logic is_end;
	logic [SAMPLE_W-1:0] s16;
	logic [STEP_W-1:0] step;
	logic [STEP_W-1:0] step_sum;
	logic [ADV_W-1:0] adv;
	logic [SP_W-1:0] loop_sp;
	logic signed [PROD_W-1:0] prod_l;
	logic signed [PROD_W-1:0] prod_r;
	logic signed [ACC_W-1:0] contrib_l;
	logic signed [ACC_W-1:0] contrib_r;
	logic mix_free;
	logic fifo_ready;

	assign sh_inc = {eng_reg.pitch_hi[OCT_LSB-1:0], eng_reg.pitch_lo};
	assign sh_oct = eng_reg.pitch_hi[OCT_LSB+:OCT_W];
	assign sh_start_wa = 16'({eng_reg.base_hi, eng_reg.base_lo} << BASE_SHIFT);
	assign sh_wide = eng_reg.shape_hi[WIDTH_BIT];
	assign sh_start_sp = sh_wide ? {1'b0, sh_start_wa} : {sh_start_wa, 1'b0};
	assign sh_loop = {eng_reg.shape_hi[WIDTH_BIT-1:0], eng_reg.loop_lo};
	assign sh_lg = {eng_reg.env_hi[LGAIN_LSB+:2], eng_reg.left_lo};
	assign sh_rg = {eng_reg.env_hi[RGAIN_LSB+:2], eng_reg.right_lo};
	assign trig_wr = reg_wr && reg_addr == ADDR_TRIGGER;
	assign trig_voice = reg_wdata[VOICE_LSB+:VOICE_W];
	assign trig_mode = reg_wdata[MODE_LSB+:MODE_W];

	assign v = eng_reg.vidx;
	assign c_sp = eng_reg.sp[v];
	assign c_frac = eng_reg.frac[v];
	assign c_inc = eng_reg.inc[v];
	assign c_oct = eng_reg.oct[v];
	assign c_wide = eng_reg.wide[v];
	assign c_loop = eng_reg.loopoff[v];
	assign c_lg = eng_reg.lg[v];
	assign c_rg = eng_reg.rg[v];
	assign c_dir = eng_reg.dir[v];
	assign c_depth = eng_reg.depth[v];
	assign mix_free = !(trig_wr && trig_voice == v);

	assign byte_pick = c_sp[0] ? eng_reg.word[15:8] : eng_reg.word[7:0];
	assign s16 = c_wide ? {eng_reg.word[15:4], 4'h0} : {byte_pick, 8'h00};
	assign is_end = c_wide ? (eng_reg.word[15:8] == END_CODE) : (byte_pick == END_CODE);
	assign step = STEP_W'(c_inc) << c_oct;
	assign step_sum = STEP_W'(c_frac) + step;
	assign adv = step_sum[STEP_W-1:FRAC_BITS];
	assign loop_sp = {c_sp[SP_W-1:LOOP_W], c_sp[LOOP_W-1:0] + c_loop};
	assign prod_l = $signed(s16) * $signed({1'b0, GAIN_MIN_LEVEL - c_lg});
	assign prod_r = $signed(s16) * $signed({1'b0, GAIN_MIN_LEVEL - c_rg});
	assign contrib_l = is_end ? '0 : ACC_W'(prod_l >>> GAIN_W);
	assign contrib_r = is_end ? '0 : ACC_W'(prod_r >>> GAIN_W);

	function automatic logic [GAIN_W-1:0] ramp_step(input logic [GAIN_W-1:0] g, input logic d,
		input logic [1:0] dep);
		logic [GAIN_W-1:0] m;
		case (dep)
			DEPTH_LOW3: m = RAMP_MASK_3;
			DEPTH_LOW2: m = RAMP_MASK_2;
			DEPTH_LOW1: m = RAMP_MASK_1;
			default: m = '0;
		endcase
		// Masks are low-contiguous, so a carry or borrow never leaves them
		if (d && (g & m) != '0) begin
			return g - 1'b1;
		end
		if (!d && m != '0 && (g & m) != m) begin
			return g + 1'b1;
		end
		return g;
	endfunction

	function automatic logic [SAMPLE_W-1:0] sat16(input logic signed [ACC_W-1:0] a);
		if (a[ACC_W-1:SAMPLE_W-1] == '0 || a[ACC_W-1:SAMPLE_W-1] == '1) begin
			return a[SAMPLE_W-1:0];
		end
		return a[ACC_W-1] ? SAT_NEG : SAT_POS;
	endfunction

	// ************************************************
	// Next state
	// ************************************************
	always_comb begin
		logic tick;
		logic pend_clr;
		logic next_voice;
		tick = 1'b0;
		pend_clr = 1'b0;
		next_voice = 1'b0;
		eng_next = eng_reg;
		tick = eng_reg.timer == PERIOD_LAST;
		eng_next.timer = tick ? '0 : eng_reg.timer + 1'b1;
		case (eng_reg.state)
			ST_IDLE: begin
				if (eng_reg.tick_pend) begin
					pend_clr = 1'b1;
					eng_next.vidx = '0;
					eng_next.state = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (eng_reg.active[v]) begin
					eng_next.fetch_addr = c_wide ? c_sp[15:0] : c_sp[SP_W-1:1];
					eng_next.state = ST_WAIT;
				end else begin
					next_voice = 1'b1;
				end
			end
			ST_WAIT: begin
				if (rom_valid) begin
					eng_next.word = rom_data;
					eng_next.state = ST_MIX;
				end
			end
			ST_MIX: begin
				next_voice = 1'b1;
				if (is_end) begin
					eng_next.sp[v] = loop_sp;
				end else begin
					eng_next.sp[v] = c_sp + SP_W'(adv);
					eng_next.frac[v] = step_sum[FRAC_BITS-1:0];
				end
				eng_next.acc_l = eng_reg.acc_l + contrib_l;
				eng_next.acc_r = eng_reg.acc_r + contrib_r;
				eng_next.lg[v] = ramp_step(c_lg, c_dir, c_depth);
				eng_next.rg[v] = ramp_step(c_rg, c_dir, c_depth);
				if (eng_next.lg[v] == GAIN_MIN_LEVEL && eng_next.rg[v] == GAIN_MIN_LEVEL) begin
					eng_next.active[v] = 1'b0;
				end
			end
			ST_PUSH: begin
				// Stalls here while the stream FIFO is full
				if (fifo_ready) begin
					eng_next.acc_l = '0;
					eng_next.acc_r = '0;
					eng_next.state = ST_IDLE;
				end
			end
			default: begin
				eng_next.state = ST_IDLE;
			end
		endcase
		if (next_voice) begin
			if (v == VOICE_LAST) begin
				eng_next.state = ST_PUSH;
			end else begin
				eng_next.vidx = v + 1'b1;
				eng_next.state = ST_FETCH;
			end
		end
		// A period tick in the same cycle as its clear stays pending
		eng_next.tick_pend = tick | (eng_reg.tick_pend & ~pend_clr);
		if (reg_wr) begin
			case (reg_addr)
				ADDR_TRIGGER: begin
					eng_next.trig = reg_wdata;
					case (trig_mode)
						MODE_ALL: begin
							eng_next.active[trig_voice] = 1'b1;
							eng_next.inc[trig_voice] = sh_inc;
							eng_next.oct[trig_voice] = sh_oct;
							eng_next.sp[trig_voice] = sh_start_sp;
							eng_next.frac[trig_voice] = '0;
							eng_next.wide[trig_voice] = sh_wide;
							eng_next.loopoff[trig_voice] = sh_loop;
							eng_next.lg[trig_voice] = sh_lg;
							eng_next.rg[trig_voice] = sh_rg;
							eng_next.dir[trig_voice] = eng_reg.env_hi[DIR_BIT];
							eng_next.depth[trig_voice] = eng_reg.env_hi[DEPTH_LSB+:2];
						end
						MODE_PITCH: begin
							eng_next.inc[trig_voice] = sh_inc;
							eng_next.oct[trig_voice] = sh_oct;
						end
						MODE_VOLUME: begin
							eng_next.lg[trig_voice] = sh_lg;
							eng_next.rg[trig_voice] = sh_rg;
						end
						default: begin
							eng_next.trig = reg_wdata;
						end
					endcase
				end
				ADDR_PITCH_HI: eng_next.pitch_hi = reg_wdata;
				ADDR_PITCH_LO: eng_next.pitch_lo = reg_wdata;
				ADDR_BASE_HI: eng_next.base_hi = reg_wdata;
				ADDR_BASE_LO: eng_next.base_lo = reg_wdata;
				ADDR_SHAPE_HI: eng_next.shape_hi = reg_wdata;
				ADDR_LOOP_LO: eng_next.loop_lo = reg_wdata;
				ADDR_ENV_HI: eng_next.env_hi = reg_wdata & ENV_HI_MASK;
				ADDR_LEFT_LO: eng_next.left_lo = reg_wdata;
				ADDR_RIGHT_LO: eng_next.right_lo = reg_wdata;
				default: eng_next.trig = eng_reg.trig;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_TRIGGER: eng_next.rdata = {eng_reg.trig[MODE_LSB+:MODE_W],
					eng_reg.active[eng_reg.trig[VOICE_LSB+:VOICE_W]], 1'b0, eng_reg.trig[VOICE_LSB+:VOICE_W]};
				ADDR_PITCH_HI: eng_next.rdata = eng_reg.pitch_hi;
				ADDR_PITCH_LO: eng_next.rdata = eng_reg.pitch_lo;
				ADDR_BASE_HI: eng_next.rdata = eng_reg.base_hi;
				ADDR_BASE_LO: eng_next.rdata = eng_reg.base_lo;
				ADDR_SHAPE_HI: eng_next.rdata = eng_reg.shape_hi;
				ADDR_LOOP_LO: eng_next.rdata = eng_reg.loop_lo;
				ADDR_ENV_HI: eng_next.rdata = eng_reg.env_hi;
				ADDR_LEFT_LO: eng_next.rdata = eng_reg.left_lo;
				ADDR_RIGHT_LO: eng_next.rdata = eng_reg.right_lo;
				default: eng_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			eng_reg <= '0;
		end else begin
			eng_reg <= eng_next;
		end
	end

	assign reg_rdata = eng_reg.rdata;
	assign sample_fetch_bus = eng_reg.fetch_addr;
	assign rom_req = eng_reg.state == ST_WAIT;

	stream_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) stream_fifo_i (
		.sys_clk(sys_clk),
		.reset(reset),
		.in_valid(eng_reg.state == ST_PUSH),
		.in_ready(fifo_ready),
		.in_data({sat16(eng_reg.acc_l), sat16(eng_reg.acc_r)}),
		.out_valid(audio_valid),
		.out_ready(audio_ready),
		.out_data({audio_left, audio_right})
	);

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_trigger_start;
		trig_wr && trig_mode == MODE_ALL |=> eng_reg.active[$past(trig_voice)]
			&& eng_reg.inc[$past(trig_voice)] == $past(sh_inc);
	endproperty
	a_trigger_start: assert property (p_trigger_start)
		else $error("trigger write did not start voice");

	property p_start_addr;
		trig_wr && trig_mode == MODE_ALL && !sh_wide |=> eng_reg.sp[$past(trig_voice)][SP_W-1:1]
			== 16'({$past(eng_reg.base_hi), $past(eng_reg.base_lo)} * 16'h0020);
	endproperty
	a_start_addr: assert property (p_start_addr)
		else $error("start address not base times 32");

	property p_pitch_only;
		trig_wr && trig_mode == MODE_PITCH && eng_reg.state != ST_MIX |=> $stable(eng_reg.sp)
			&& $stable(eng_reg.lg) && eng_reg.inc[$past(trig_voice)] == $past(sh_inc);
	endproperty
	a_pitch_only: assert property (p_pitch_only)
		else $error("pitch-only update touched other fields");

	property p_volume_only;
		trig_wr && trig_mode == MODE_VOLUME && eng_reg.state != ST_MIX |=> $stable(eng_reg.inc)
			&& $stable(eng_reg.sp) && eng_reg.rg[$past(trig_voice)] == $past(sh_rg);
	endproperty
	a_volume_only: assert property (p_volume_only)
		else $error("volume-only update wrong");

	property p_unity_rate;
		eng_reg.state == ST_MIX && c_inc == UNITY_INC && c_oct == UNITY_OCT |-> adv == ADV_W'(1);
	endproperty
	a_unity_rate: assert property (p_unity_rate)
		else $error("unity pitch did not advance one sample");

	property p_rate_law;
		eng_reg.state == ST_MIX && !is_end && mix_free |=>
			34'({eng_reg.sp[$past(v)], eng_reg.frac[$past(v)]} - {$past(c_sp), $past(c_frac)})
			== 34'(34'($past(c_inc)) << $past(c_oct));
	endproperty
	a_rate_law: assert property (p_rate_law)
		else $error("position advance wrong");

	property p_width_fetch;
		eng_reg.state == ST_FETCH && eng_reg.active[v] |=> rom_req
			&& sample_fetch_bus == ($past(c_wide) ? 16'($past(c_sp)) : 16'($past(c_sp) >> 1));
	endproperty
	a_width_fetch: assert property (p_width_fetch)
		else $error("fetch address wrong for width");

	property p_loop_jump;
		eng_reg.state == ST_MIX && is_end && mix_free |=>
			eng_reg.sp[$past(v)][LOOP_W-1:0] == LOOP_W'($past(c_sp) + SP_W'($past(c_loop)));
	endproperty
	a_loop_jump: assert property (p_loop_jump)
		else $error("loop jump address wrong");

	property p_end_silent;
		eng_reg.state == ST_MIX && is_end |=> eng_reg.acc_l == $past(eng_reg.acc_l)
			&& eng_reg.acc_r == $past(eng_reg.acc_r);
	endproperty
	a_end_silent: assert property (p_end_silent)
		else $error("end code was mixed as a sample");

	property p_attack_step;
		eng_reg.state == ST_MIX && mix_free && c_dir && c_depth == DEPTH_LOW3
			&& (c_lg & RAMP_MASK_3) != '0 |=> eng_reg.lg[$past(v)] == $past(c_lg) - 10'h001;
	endproperty
	a_attack_step: assert property (p_attack_step)
		else $error("attack ramp step wrong");

	property p_depth_hold;
		eng_reg.state == ST_MIX && mix_free && c_depth == DEPTH_NONE |=>
			eng_reg.lg[$past(v)] == $past(c_lg) && eng_reg.rg[$past(v)] == $past(c_rg);
	endproperty
	a_depth_hold: assert property (p_depth_hold)
		else $error("depth 11 changed volume");

	c_loop_seen: cover property (eng_reg.state == ST_MIX && is_end);
	c_push_done: cover property (eng_reg.state == ST_PUSH && fifo_ready);
	c_fifo_stall: cover property (eng_reg.state == ST_PUSH && !fifo_ready);
	c_attack_seen: cover property (eng_reg.state == ST_MIX && c_dir && c_depth == DEPTH_LOW1);
endmodule

/* tb/wave_rom_model.sv */
// Behavioural wave ROM answering the engine's sample fetches
`timescale 1ns/1ps
module wave_rom_model (
	// Clock
	input wire logic sys_clk,
	// Fetch port
	input wire logic [15:0] sample_fetch_bus,
	input wire logic rom_req,
	output logic rom_valid,
	output logic [15:0] rom_data,
	// Answer speed
	input wire logic slow
);
	logic [15:0] mem [64];
	logic [1:0] wait_cnt;
	initial begin
		rom_valid = 1'b0;
		rom_data = 16'h0000;
		wait_cnt = 2'h0;
	end
	// One word per request; a slow answer waits two cycles
	always @(posedge sys_clk) begin
		if (rom_req && !rom_valid && wait_cnt >= (slow ? 2'h2 : 2'h0)) begin
			rom_valid <= 1'b1;
			rom_data <= mem[sample_fetch_bus[5:0]];
			wait_cnt <= 2'h0;
		end else begin
			// Released bus inverts its word on every idle cycle
			rom_valid <= 1'b0;
			rom_data <= ~rom_data;
			wait_cnt <= (rom_req && !rom_valid) ? wait_cnt + 2'h1 : 2'h0;
		end
	end
endmodule

/* tb/wavetable_voice_engine_tb.sv */
// Self-checking bench for the wavetable voice engine
`timescale 1ns/1ps
module wavetable_voice_engine_tb
	import wavetable_pkg::*;
;
	logic sys_clk, reset, reg_wr, reg_rd, rom_req, rom_valid, audio_valid, audio_ready, slow, seen;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [15:0] sample_fetch_bus, rom_data, audio_left, audio_right, first_addr;
	logic [7:0] seq [7] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'hf0, 8'h00};
	int fails, n_tests;
	wavetable_voice_engine wavetable_voice_engine_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sample_fetch_bus(sample_fetch_bus), .rom_req(rom_req), .rom_valid(rom_valid), .rom_data(rom_data),
		.audio_valid(audio_valid), .audio_ready(audio_ready), .audio_left(audio_left), .audio_right(audio_right));
	wave_rom_model wave_rom_model_i (.sys_clk(sys_clk), .sample_fetch_bus(sample_fetch_bus), .rom_req(rom_req),
		.rom_valid(rom_valid), .rom_data(rom_data), .slow(slow));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (rom_req === 1'b1 && !seen) begin
		seen <= 1'b1;
		first_addr <= sample_fetch_bus;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic ok);
		n_tests++;
		if (ok !== 1'b1) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, ok, 1'b1);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		chk({8'h00, reg_rdata}, {8'h00, e});
	endtask
	task automatic periods(input int n);
		repeat (n * PERIOD_CYCLES) @(negedge sys_clk);
	endtask
	// Contribution of one 8-bit sample at a given attenuation
	function automatic logic [15:0] mix(input logic [7:0] s, input logic [9:0] a);
		logic signed [31:0] p;
		p = $signed({{16{s[7]}}, s, 8'h00}) * $signed({22'h0, 10'h3ff - a});
		return 16'(p >>> 10);
	endfunction
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs;
		logic [7:0] a;
		for (int i = 0; i < 10; i++) rdchk(8'h21 + 8'(i), 8'h00);
		for (int i = 0; i < 10; i++) wr(8'h21 + 8'(i), 8'hc5 ^ 8'(i));
		for (int i = 0; i < 10; i++) begin
			a = 8'h21 + 8'(i);
			rdchk(a, (a == 8'h28) ? 8'h00 : (a == ADDR_ENV_HI) ? ((8'hc5 ^ 8'(i)) & ENV_HI_MASK) : 8'hc5 ^ 8'(i));
		end
		rdchk(8'h1f, 8'h00);
		$display("register test done");
	endtask
	task automatic test_stream;
		int i, cnt, k;
		// Signed bytes, two per word, closed by end codes
		wave_rom_model_i.mem[32] = 16'h2010;
		wave_rom_model_i.mem[33] = 16'h4030;
		wave_rom_model_i.mem[34] = 16'hf050;
		wave_rom_model_i.mem[35] = 16'h8080;
		wr(ADDR_PITCH_HI, 8'h68);
		wr(ADDR_PITCH_LO, 8'h00);
		wr(ADDR_BASE_HI, 8'h00);
		wr(ADDR_BASE_LO, 8'h03);
		wr(ADDR_SHAPE_HI, 8'h7f);
		wr(ADDR_LOOP_LO, 8'hfc);
		wr(ADDR_ENV_HI, 8'h0d);
		wr(ADDR_LEFT_LO, 8'h00);
		wr(ADDR_RIGHT_LO, 8'h00);
		wr(ADDR_TRIGGER, 8'h00);
		rdchk(ADDR_TRIGGER, 8'h20);
		periods(34);
		chk(first_addr, 16'h0060);
		cnt = 0;
		i = 0;
		audio_ready = 1'b1;
		while (cnt < 40 && audio_valid === 1'b1) begin
			if (i > 0 || audio_left !== 16'h0000) begin
				k = (i < 7) ? i : 2 + (i - 2) % 5;
				chk(audio_left, mix(seq[k], 10'h000));
				chk(audio_right, mix(seq[k], 10'h100));
				i++;
			end
			cnt++;
			@(negedge sys_clk);
		end
		chkb(cnt >= 32 && cnt <= 34);
		chkb(i > 12);
		$display("stream test done");
	endtask
	task automatic test_ramp_modes;
		slow = 1'b1;
		wr(ADDR_ENV_HI, 8'h33);
		wr(ADDR_LEFT_LO, 8'hfc);
		wr(ADDR_RIGHT_LO, 8'hfc);
		wr(ADDR_TRIGGER, 8'h02);
		rdchk(ADDR_TRIGGER, 8'h22);
		periods(1);
		rdchk(ADDR_TRIGGER, 8'h22);
		periods(4);
		rdchk(ADDR_TRIGGER, 8'h02);
		wr(ADDR_ENV_HI, 8'h0c);
		wr(ADDR_LEFT_LO, 8'h00);
		wr(ADDR_RIGHT_LO, 8'h00);
		wr(ADDR_TRIGGER, 8'h03);
		wr(ADDR_ENV_HI, 8'h3f);
		wr(ADDR_LEFT_LO, 8'hff);
		wr(ADDR_RIGHT_LO, 8'hff);
		wr(ADDR_TRIGGER, 8'h43);
		periods(2);
		rdchk(ADDR_TRIGGER, 8'h63);
		wr(ADDR_TRIGGER, 8'h83);
		periods(2);
		rdchk(ADDR_TRIGGER, 8'h83);
		wr(ADDR_TRIGGER, 8'hc3);
		rdchk(ADDR_TRIGGER, 8'hc3);
		// Attack on the three low bits keeps the voice sounding
		wr(ADDR_ENV_HI, 8'h80);
		wr(ADDR_LEFT_LO, 8'h07);
		wr(ADDR_RIGHT_LO, 8'h07);
		wr(ADDR_TRIGGER, 8'h04);
		periods(2);
		rdchk(ADDR_TRIGGER, 8'h24);
		$display("ramp and mode test done");
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		audio_ready = 1'b0;
		slow = 1'b0;
		seen = 1'b0;
		fails = 0;
		n_tests = 0;
		repeat (3) @(negedge sys_clk);
		reset = 1'b0;
		test_regs;
		test_stream;
		test_ramp_modes;
		final_report;
	end
	initial begin
		#990000;
		fails++;
		final_report;
	end
endmodule
